//--- pkg/swpm_params.svh
`ifndef SWPM_PARAMS_SVH
`define SWPM_PARAMS_SVH
`define SWPM_A_CTRL 12'h000
`define SWPM_A_STAT 12'h004
`define SWPM_A_WAKECFG 12'h008
`define SWPM_A_CMPLO 12'h00c
`define SWPM_A_CMPHI 12'h010
`define SWPM_A_INC 12'h014
`define SWPM_A_CNTLO 12'h018
`define SWPM_A_CNTHI 12'h01c
`define SWPM_A_SLPCFG 12'h020
`define SWPM_A_DSMEM 12'h080
`define SWPM_DSMEM_WORDS 32
`define SWPM_B_SLEEP 0
`define SWPM_B_SLOWEN 1
`define SWPM_B_PINEN 0
`define SWPM_B_TMREN 3
`define SWPM_INC_RST 32'h00000001
`define SWPM_CMP_RST 64'hffffffffffffffff
`define SWPM_SLPCFG_RST 32'h00000000
`define SWPM_STEP_NS 64
`define SWPM_STEP_CYC ((`SWPM_STEP_NS + 7) / 8)
`endif

//--- pkg/swpm_pkg.sv
package swpm_pkg;
   typedef enum logic [2:0]
   {
      SW_AWAKE, SW_GO_SLEEP1, SW_GO_SLEEP2, SW_ASLEEP, SW_WAKE1, SW_WAKE2
   } swpm_state_t;
   // wake pin mode: 0 high level, 1 low level, 2 rising, 3 falling
   typedef logic [1:0] swpm_pinmode_t;
endpackage : swpm_pkg

//--- pkg/swpm_rtc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swpm_rtc_if;
   logic asleep;
   logic slow_en;
   logic [31:0] inc;
   logic [63:0] cmp;
   logic wr_lo;
   logic wr_hi;
   logic [31:0] wdata;
   logic [63:0] count;
   logic match;
   modport ctl (output asleep, slow_en, inc, cmp, wr_lo, wr_hi, wdata,
      input count, match);
   modport rtc (input asleep, slow_en, inc, cmp, wr_lo, wr_hi, wdata,
      output count, match);
endinterface : swpm_rtc_if
`default_nettype wire

//--- src/swpm_rtc.sv
`timescale 1ns/1ps
`default_nettype none
module swpm_rtc
   import swpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic slow_tick,
   swpm_rtc_if.rtc r
);
   logic [63:0] cnt_q;
   logic [63:0] step;
   always_comb
   begin
      step = 64'h1;
      if (r.asleep && r.slow_en)
         step = {32'h0, r.inc};
   end
   // ************************************************
   // counter
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_q <= 64'h0;
      else if (ce)
      begin
         if (r.wr_lo)
            cnt_q <= {cnt_q[63:32], r.wdata};
         else if (r.wr_hi)
            cnt_q <= {r.wdata, cnt_q[31:0]};
         else if (!(r.asleep && r.slow_en) || slow_tick)
            cnt_q <= cnt_q + step;
      end
   end
   assign r.count = cnt_q;
   assign r.match = (cnt_q >= r.cmp);
   a_slow_hold: assert property (@(posedge clk)
      disable iff (!rst_n)
      (ce && r.asleep && r.slow_en && !slow_tick && !r.wr_lo && !r.wr_hi)
      |=> $stable(cnt_q))
      else $error("counter moved without slow tick");
   a_awake_inc: assert property (@(posedge clk)
      disable iff (!rst_n)
      (rst_n && ce && !r.asleep && !r.wr_lo && !r.wr_hi)
      |=> cnt_q == $past(cnt_q) + 64'h1)
      else $error("awake counter did not step by one");
   a_slow_add: assert property (@(posedge clk)
      disable iff (!rst_n)
      (ce && r.asleep && r.slow_en && slow_tick && !r.wr_lo && !r.wr_hi)
      |=> cnt_q == $past(cnt_q) + {32'h0, $past(r.inc)})
      else $error("slow tick did not add increment");
endmodule : swpm_rtc
`default_nettype wire

//--- src/swpm_wake.sv
`timescale 1ns/1ps
`default_nettype none
module swpm_wake
   import swpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   input wire swpm_pinmode_t mode,
   input wire logic arm,
   input wire logic clr,
   output logic hit
);
   logic pin_q;
   logic ev;
   logic hit_q;
   always_comb
   begin
      case (mode)
         2'h0: ev = pin;
         2'h1: ev = !pin;
         2'h2: ev = pin && !pin_q;
         2'h3: ev = !pin && pin_q;
         default: ev = 1'b0;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pin_q <= 1'b0;
      else if (ce)
         pin_q <= pin;
   end
   // latched event, set wins over clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         hit_q <= 1'b0;
      else if (ce)
      begin
         if (arm && ev)
            hit_q <= 1'b1;
         else if (clr)
            hit_q <= 1'b0;
      end
   end
   assign hit = hit_q;
   a_edge_catch: assert property (@(posedge clk)
      disable iff (!rst_n)
      (ce && arm && mode == 2'h2 && pin && !pin_q) |=> hit_q)
      else $error("rising wake edge missed");
endmodule : swpm_wake
`default_nettype wire

//--- src/swpm_top.sv
`include "swpm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module swpm_top
   import swpm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic WAKE_PIN,
   input wire logic SLOW_TICK,
   input wire logic POWER_GOOD,
   output logic CORE_PWR_EN,
   output logic PERIPH_PWR_EN,
   output logic IO_SUPPLY_EN,
   output logic WDOG_EN,
   output logic SYS_RESET,
   output logic [31:0] SLEEP_CFG
);
   // ************************************************
   // declarations
   // ************************************************
   swpm_rtc_if rif();
   swpm_state_t st_q;
   swpm_state_t st_d;
   logic [2:0] tmr_q;
   logic slow_en_q;
   logic [2:0] wcfg_q;
   logic [31:0] inc_q;
   logic [63:0] cmp_q;
   logic [31:0] slp_q;
   logic [31:0] mem [0:`SWPM_DSMEM_WORDS-1];
   logic [31:0] rdata_q;
   logic err_q;
   logic rst_q;
   logic wr;
   logic rd;
   logic mem_sel;
   logic sleep_req;
   logic pin_hit;
   logic wake_go;
   logic tmr_done;
   logic in_trans;
   logic [31:0] wmask;

   function automatic logic [31:0] lanes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : lanes

   assign wr = PSEL && PENABLE && PWRITE && CE;
   assign rd = PSEL && PENABLE && !PWRITE && CE;
   assign mem_sel = PADDR[11:7] == 5'(`SWPM_A_DSMEM >> 7);
   assign wmask = lanes(32'h0, 32'hffffffff, PSTRB);
   assign sleep_req = wr && PADDR == `SWPM_A_CTRL && PSTRB[0]
      && PWDATA[`SWPM_B_SLEEP];

   // ************************************************
   // sub blocks
   // ************************************************
   swpm_rtc u_rtc
   (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .slow_tick(SLOW_TICK),
      .r(rif.rtc)
   );
   assign rif.asleep = st_q == SW_ASLEEP;
   assign rif.slow_en = slow_en_q;
   assign rif.inc = inc_q;
   assign rif.cmp = cmp_q;
   assign rif.wr_lo = wr && PADDR == `SWPM_A_CNTLO;
   assign rif.wr_hi = wr && PADDR == `SWPM_A_CNTHI;
   assign rif.wdata = PWDATA;

   // pin events arm once the state has left SW_AWAKE and clear while awake
   swpm_wake u_wake
   (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .pin(WAKE_PIN),
      .mode(swpm_pinmode_t'(wcfg_q[2:1])),
      .arm(wcfg_q[`SWPM_B_PINEN] && st_q != SW_AWAKE),
      .clr(st_q == SW_AWAKE),
      .hit(pin_hit)
   );

   // timer compare is a level, so a match during entry persists
   assign wake_go = pin_hit
      || (slp_q[`SWPM_B_TMREN] && rif.match);

   // ************************************************
   // power state machine
   // ************************************************
   assign tmr_done = tmr_q == 3'(`SWPM_STEP_CYC - 1);
   assign in_trans = st_q != SW_AWAKE && st_q != SW_ASLEEP;
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         SW_AWAKE:
            if (sleep_req)
               st_d = SW_GO_SLEEP1;
         SW_GO_SLEEP1:
            if (tmr_done)
               st_d = SW_GO_SLEEP2;
         SW_GO_SLEEP2:
            if (tmr_done)
               st_d = SW_ASLEEP;
         SW_ASLEEP:
            if (wake_go)
               st_d = SW_WAKE1;
         SW_WAKE1:
            if (tmr_done)
               st_d = SW_WAKE2;
         SW_WAKE2:
            if (tmr_done)
               st_d = SW_AWAKE;
         default:
            st_d = SW_AWAKE;
      endcase
      if (in_trans && !POWER_GOOD)
         st_d = SW_AWAKE;
   end
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         st_q <= SW_AWAKE;
      else if (CE)
         st_q <= st_d;
   end
   // sub-state step counter, restarts on every state change
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         tmr_q <= 3'h0;
      else if (CE)
      begin
         if (st_d != st_q || !in_trans)
            tmr_q <= 3'h0;
         else
            tmr_q <= tmr_q + 3'h1;
      end
   end
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         rst_q <= 1'b0;
      else if (CE)
         rst_q <= in_trans && !POWER_GOOD;
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         slow_en_q <= 1'b0;
         wcfg_q <= 3'h0;
         inc_q <= `SWPM_INC_RST;
         cmp_q <= `SWPM_CMP_RST;
         slp_q <= `SWPM_SLPCFG_RST;
      end
      else if (wr)
      begin
         case (PADDR)
            `SWPM_A_CTRL:
               if (PSTRB[0])
                  slow_en_q <= PWDATA[`SWPM_B_SLOWEN];
            `SWPM_A_WAKECFG:
               if (PSTRB[0])
                  wcfg_q <= PWDATA[2:0];
            `SWPM_A_CMPLO:
               cmp_q[31:0] <= lanes(cmp_q[31:0], PWDATA, PSTRB);
            `SWPM_A_CMPHI:
               cmp_q[63:32] <= lanes(cmp_q[63:32], PWDATA, PSTRB);
            `SWPM_A_INC:
               inc_q <= lanes(inc_q, PWDATA, PSTRB);
            `SWPM_A_SLPCFG:
               slp_q <= lanes(slp_q, PWDATA, PSTRB);
            default:
               slp_q <= slp_q;
         endcase
      end
   end
   // deep sleep memory has no reset so contents survive sleep
   always_ff @(posedge CLK)
   begin
      if (wr && mem_sel)
         mem[PADDR[6:2]] <= (mem[PADDR[6:2]] & ~wmask) | (PWDATA & wmask);
   end
   // read data is captured in the setup phase
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         rdata_q <= 32'h0;
         err_q <= 1'b0;
      end
      else if (CE && PSEL && !PENABLE)
      begin
         err_q <= 1'b0;
         if (mem_sel)
            rdata_q <= mem[PADDR[6:2]];
         else
         begin
            case (PADDR)
               `SWPM_A_CTRL:
                  rdata_q <= {30'h0, slow_en_q, 1'b0};
               `SWPM_A_STAT:
                  rdata_q <= {27'h0, pin_hit, rif.match, 3'(st_q)};
               `SWPM_A_WAKECFG:
                  rdata_q <= {29'h0, wcfg_q};
               `SWPM_A_CMPLO:
                  rdata_q <= cmp_q[31:0];
               `SWPM_A_CMPHI:
                  rdata_q <= cmp_q[63:32];
               `SWPM_A_INC:
                  rdata_q <= inc_q;
               `SWPM_A_CNTLO:
                  rdata_q <= rif.count[31:0];
               `SWPM_A_CNTHI:
                  rdata_q <= rif.count[63:32];
               `SWPM_A_SLPCFG:
                  rdata_q <= slp_q;
               default:
               begin
                  rdata_q <= 32'h0;
                  err_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign PRDATA = rdata_q;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && err_q;
   assign CORE_PWR_EN = st_q != SW_ASLEEP;
   assign PERIPH_PWR_EN = st_q != SW_ASLEEP;
   assign IO_SUPPLY_EN = st_q == SW_AWAKE;
   assign WDOG_EN = st_q == SW_AWAKE;
   assign SYS_RESET = rst_q;
   assign SLEEP_CFG = slp_q;

   // ************************************************
   // checks
   // ************************************************
   sequence s_asleep_wake;
      st_q == SW_ASLEEP && wake_go && POWER_GOOD && CE;
   endsequence
   sequence s_sleep_go;
      CE && st_q == SW_AWAKE && sleep_req;
   endsequence
   // one transition sub-state with the supplies good
   sequence s_step8;
      (CE && POWER_GOOD) [*8];
   endsequence

   a_wake_start: assert property (@(posedge CLK)
      disable iff (!RST_N) s_asleep_wake |=> st_q == SW_WAKE1)
      else $error("wake not started");
   a_wake_time: assert property (@(posedge CLK)
      disable iff (!RST_N)
      s_asleep_wake ##1 s_step8 ##1 s_step8 |=> st_q == SW_AWAKE)
      else $error("wake sequence took wrong time");
   a_entry_time: assert property (@(posedge CLK)
      disable iff (!RST_N)
      s_sleep_go ##1 s_step8 ##1 s_step8 |=> st_q == SW_ASLEEP)
      else $error("sleep entry took wrong time");

   a_awake_hold: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (st_q == SW_AWAKE && !sleep_req) |=> st_q == SW_AWAKE)
      else $error("left awake without sleep request");
   a_sleep_start: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (st_q == SW_AWAKE && sleep_req) |=> st_q == SW_GO_SLEEP1)
      else $error("sleep request not taken");
   a_trans_ignore: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (st_q == SW_GO_SLEEP1 && sleep_req && POWER_GOOD && !tmr_done)
      |=> st_q == SW_GO_SLEEP1)
      else $error("sleep write disturbed transition");
   a_asleep_ignore: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && st_q == SW_ASLEEP && sleep_req && !wake_go)
      |=> st_q == SW_ASLEEP)
      else $error("sleep write disturbed sleep");
   a_trans_hold: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && in_trans && POWER_GOOD && !tmr_done)
      |=> st_q == $past(st_q))
      else $error("transition step ended early");

   a_pg_reset: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && in_trans && !POWER_GOOD) |=> SYS_RESET)
      else $error("no reset on power-good loss");
   a_pg_return: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && in_trans && !POWER_GOOD) |=> st_q == SW_AWAKE)
      else $error("power-good loss did not abort transition");
   a_reset_pulse: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && SYS_RESET) |=> !SYS_RESET)
      else $error("system reset held too long");

   a_io_supply: assert property (@(posedge CLK)
      disable iff (!RST_N)
      IO_SUPPLY_EN == (st_q == SW_AWAKE) && WDOG_EN == IO_SUPPLY_EN)
      else $error("io supply or watchdog on outside awake");
   a_io_drop: assert property (@(posedge CLK)
      disable iff (!RST_N)
      $fell(IO_SUPPLY_EN) |-> $past(sleep_req))
      else $error("io supply dropped without sleep request");
   a_asleep_power: assert property (@(posedge CLK)
      disable iff (!RST_N)
      st_q == SW_ASLEEP |-> !CORE_PWR_EN && !PERIPH_PWR_EN)
      else $error("core powered while asleep");
   a_pin_clear: assert property (@(posedge CLK)
      disable iff (!RST_N)
      (CE && st_q == SW_AWAKE) |=> !pin_hit)
      else $error("stale pin wake kept while awake");
endmodule : swpm_top
`default_nettype wire

//--- tb/swpm_env_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external wake pin and supply monitor
// ****************************************
module swpm_env_model
(
   input wire logic clk,
   input wire logic pin_req,
   input wire logic pg_drop,
   output logic wake_pin,
   output logic power_good
);
   always @(posedge clk)
   begin
      wake_pin <= pin_req;
      power_good <= ~pg_drop;
   end
endmodule : swpm_env_model
`default_nettype wire

//--- tb/testbench.sv
`include "swpm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import swpm_pkg::*;
   logic clk, rst_n, psel, pen, pwr, pin_req, pg_drop, tick, pin, pg, ce;
   logic [11:0] paddr;
   logic [31:0] pwd, prdata, rd, c0, cfg;
   logic pready, pslverr, err, core, periph, io, wdog, sysrst;
   int fail_count, n_tests, cyc, slp_cyc, rst_cnt;
   swpm_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
      .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WAKE_PIN(pin), .SLOW_TICK(tick), .POWER_GOOD(pg),
      .CORE_PWR_EN(core), .PERIPH_PWR_EN(periph), .IO_SUPPLY_EN(io),
      .WDOG_EN(wdog), .SYS_RESET(sysrst), .SLEEP_CFG(cfg));
   swpm_env_model env (.clk(clk), .pin_req(pin_req), .pg_drop(pg_drop),
      .wake_pin(pin), .power_good(pg));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (core === 1'b0)
         slp_cyc <= slp_cyc + 1;
      if (sysrst === 1'b1)
         rst_cnt <= rst_cnt + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         final_report();
      end
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task final_report();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task wait_out(input logic sel_io, input logic lvl);
      int i;
      for (i = 0; i < 60; i++)
      begin
         if ((sel_io ? io : core) === lvl)
            break;
         @(posedge clk);
      end
   endtask : wait_out
   task pulse_tick();
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
   endtask : pulse_tick
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset();
      chk({core, periph, io, wdog, sysrst}, 5'b11110);
      apb(1'b0, `SWPM_A_STAT, 32'h0);
      chk(rd[2:0], 3'd0);
      apb(1'b0, `SWPM_A_INC, 32'h0);
      chk(rd, `SWPM_INC_RST);
      apb(1'b0, `SWPM_A_CMPHI, 32'h0);
      chk(rd, 32'hffffffff);
      apb(1'b0, 12'h040, 32'h0);
      chk({err, rd}, 33'h100000000);
   endtask : t_reset
   task t_freeze();
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      c0 = rd;
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      chk(rd - c0, 32'd3);
      chk({io, core}, 2'b11);
   endtask : t_freeze
   task t_pin(input logic [1:0] mode);
      logic idle;
      idle = mode[0];
      pin_req <= idle;
      apb(1'b1, `SWPM_A_WAKECFG, {29'h0, mode, 1'b1});
      pin_req <= ~idle;
      repeat (4) @(posedge clk);
      pin_req <= idle;
      apb(1'b0, `SWPM_A_STAT, 32'h0);
      chk(rd[2:0], 3'd0);
      apb(1'b1, `SWPM_A_DSMEM + 12'(mode) * 12'd4, 32'hc0de0000 + mode);
      apb(1'b1, `SWPM_A_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk({io, wdog, core}, 3'b001);
      wait_out(1'b0, 1'b0);
      chk({core, periph}, 2'b00);
      apb(1'b1, `SWPM_A_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      apb(1'b0, `SWPM_A_STAT, 32'h0);
      chk(rd[2:0], 3'd3);
      pin_req <= ~idle;
      wait_out(1'b1, 1'b1);
      chk({io, wdog, core}, 3'b111);
      pin_req <= idle;
      apb(1'b0, `SWPM_A_DSMEM + 12'(mode) * 12'd4, 32'h0);
      chk(rd, 32'hc0de0000 + mode);
   endtask : t_pin
   task t_pending();
      int s;
      pin_req <= 1'b0;
      apb(1'b1, `SWPM_A_WAKECFG, 32'h5);
      apb(1'b1, `SWPM_A_CTRL, 32'h1);
      apb(1'b1, `SWPM_A_CTRL, 32'h1);
      apb(1'b0, `SWPM_A_STAT, 32'h0);
      chk(rd[2:0], 3'd1);
      repeat (3) @(posedge clk);
      s = slp_cyc;
      pin_req <= 1'b1;
      repeat (4) @(posedge clk);
      wait_out(1'b1, 1'b1);
      chk(io, 1'b1);
      chk(slp_cyc > s, 1'b1);
      pin_req <= 1'b0;
   endtask : t_pending
   task t_timer();
      apb(1'b1, `SWPM_A_WAKECFG, 32'h0);
      apb(1'b1, `SWPM_A_INC, 32'd1000);
      apb(1'b1, `SWPM_A_CMPHI, 32'h0);
      apb(1'b1, `SWPM_A_CMPLO, 32'd2500);
      apb(1'b1, `SWPM_A_CNTHI, 32'h0);
      apb(1'b1, `SWPM_A_CNTLO, 32'h0);
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      c0 = rd;
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      chk(rd - c0, 32'd3);
      apb(1'b1, `SWPM_A_SLPCFG, 32'h000000f8);
      @(posedge clk);
      chk(cfg, 32'h000000f8);
      apb(1'b1, `SWPM_A_CTRL, 32'h3);
      wait_out(1'b0, 1'b0);
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      c0 = rd;
      repeat (10) @(posedge clk);
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      chk(rd, c0);
      pulse_tick();
      pulse_tick();
      apb(1'b0, `SWPM_A_CNTLO, 32'h0);
      chk(rd - c0, 32'd2000);
      chk(core, 1'b0);
      pulse_tick();
      wait_out(1'b1, 1'b1);
      chk({io, core}, 2'b11);
      apb(1'b1, `SWPM_A_SLPCFG, 32'h0);
      apb(1'b1, `SWPM_A_CTRL, 32'h0);
   endtask : t_timer
   task t_pg();
      int s;
      apb(1'b1, `SWPM_A_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      s = rst_cnt;
      pg_drop <= 1'b1;
      repeat (6) @(posedge clk);
      pg_drop <= 1'b0;
      chk(rst_cnt - s, 32'd1);
      apb(1'b0, `SWPM_A_STAT, 32'h0);
      chk({io, rd[2:0]}, 4'b1000);
   endtask : t_pg
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwd = 32'h0;
      pin_req = 1'b0;
      pg_drop = 1'b0;
      tick = 1'b0;
      ce = 1'b1;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      slp_cyc = 0;
      rst_cnt = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_freeze();
      for (int m = 0; m < 4; m++)
         t_pin(m[1:0]);
      t_pending();
      t_timer();
      t_pg();
      final_report();
   end
endmodule : testbench
`default_nettype wire
